/* File: common/bcd_dec_consts.vh */
// Constants for the decimal adjust and decrement datapath.
// Included by the datapath modules; definitions only.
`ifndef BCD_DEC_CONSTS_VH
`define BCD_DEC_CONSTS_VH

// ----------------------------------------------------------------
// Nibble correction
// ----------------------------------------------------------------
`define NIB_LIMIT 4'h9
`define NIB_CORR 4'h6

// ----------------------------------------------------------------
// Operand addressing
// ----------------------------------------------------------------
`define IDX_MAX 8'h5f
`define ACC_BANK 4'hf
`define DEST_ACC 1'b0
`define DEST_REG 1'b1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACC_RST 8'h00
`define BYTE_RST 8'h00
`define ADDR_RST 12'h000
`define FLAGS_RST 5'h00

// ----------------------------------------------------------------
// Status bit positions in flag vector {n, ov, z, dc, c}
// ----------------------------------------------------------------
`define FL_C 0
`define FL_DC 1
`define FL_Z 2
`define FL_OV 3
`define FL_N 4
`define FLAGS_ALL 5'h1f

`endif

/* File: rtl/nibble_adjust.v */
// One nibble of the decimal adjust: adds six when above nine or forced.
// Assumes a pure combinational context; no clock.
`timescale 1ns/100ps
`include "bcd_dec_consts.vh"

module nibble_adjust
(
  input wire [3:0] nib_in,
  input wire force_corr,
  output wire [3:0] nib_out,
  output wire corr_done,
  output wire carry_out
);

  wire [4:0] sum;

  assign corr_done = (nib_in > `NIB_LIMIT) | force_corr;
  assign sum = {1'b0, nib_in} + {1'b0, (corr_done ? `NIB_CORR : 4'h0)};
  assign nib_out = sum[3:0];
  assign carry_out = sum[4];

endmodule // nibble_adjust

/* File: rtl/bcd_adjust_and_decrement_unit.v */
// Execution datapath for decimal adjust of the accumulator and register decrement.
// Assumes the core presents one operation per clock with its operands already read.
`timescale 1ns/100ps
`include "bcd_dec_consts.vh"

module bcd_adjust_and_decrement_unit
(
  input wire core_clk,
  input wire arst_n,
  input wire daw_go,
  input wire dec_go,
  input wire [7:0] acc_in,
  input wire [7:0] reg_in,
  input wire [7:0] register_operand,
  input wire result_target_bit,
  input wire in_fixed_pool,
  input wire ext_set_en,
  input wire [3:0] bank_pointer,
  input wire [7:0] index_base,
  input wire half_overflow_bit,
  input wire nibble_overflow_bit,
  output reg [7:0] acc_out,
  output reg acc_we,
  output reg [7:0] reg_wdata,
  output reg [11:0] reg_addr,
  output reg reg_we,
  output reg indexed_mode,
  output reg [4:0] flags_out,
  output reg [4:0] flags_we,
  output reg busy
);

  // ----------------------------------------------------------------
  // State encoding
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_EXEC = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;

  // ----------------------------------------------------------------
  // Decimal adjust
  // ----------------------------------------------------------------
  wire [3:0] lo_adj;
  wire [3:0] hi_adj;
  wire lo_corr;
  wire hi_corr;
  wire lo_cy;
  wire hi_cy;
  wire [4:0] hi_sum;
  wire hi_force;

  nibble_adjust u_lo
  (
    .nib_in(acc_in[3:0]),
    .force_corr(half_overflow_bit),
    .nib_out(lo_adj),
    .corr_done(lo_corr),
    .carry_out(lo_cy)
  );

  // The low correction may ripple a carry into the high nibble. An F nibble
  // that overflows there wraps to 0 and must still be corrected, else the
  // decimal carry out of the byte is lost.
  assign hi_sum = {1'b0, acc_in[7:4]} + {4'h0, lo_cy};
  assign hi_force = nibble_overflow_bit | hi_sum[4];

  nibble_adjust u_hi
  (
    .nib_in(hi_sum[3:0]),
    .force_corr(hi_force),
    .nib_out(hi_adj),
    .corr_done(hi_corr),
    .carry_out(hi_cy)
  );

  wire [7:0] daw_res;
  wire daw_carry;
  assign daw_res = {hi_adj, lo_adj};
  assign daw_carry = hi_corr | hi_cy | nibble_overflow_bit;

  // ----------------------------------------------------------------
  // Decrement and addressing
  // ----------------------------------------------------------------
  wire [7:0] dec_res;
  wire dec_c;
  wire dec_dc;
  wire dec_ov;
  wire use_index;
  wire [11:0] ea;
  wire [8:0] idx_full;
  wire [7:0] idx_sum;
  wire dec_n;
  wire dec_z;
  reg [4:0] dec_flags;
  reg [4:0] daw_flags;

  assign dec_res = reg_in - 8'h01;
  // Borrow flags follow the subtract convention: set means no borrow
  assign dec_c = (reg_in != 8'h00);
  assign dec_dc = (reg_in[3:0] != 4'h0);
  assign dec_ov = (reg_in == 8'h80);
  assign dec_n = dec_res[7];
  assign dec_z = (dec_res == 8'h00);

  // Flag vectors are packed by bit position so the layout lives in one place
  always @*
  begin
    dec_flags = `FLAGS_RST;
    dec_flags[`FL_C] = dec_c;
    dec_flags[`FL_DC] = dec_dc;
    dec_flags[`FL_Z] = dec_z;
    dec_flags[`FL_OV] = dec_ov;
    dec_flags[`FL_N] = dec_n;
    daw_flags = `FLAGS_RST;
    daw_flags[`FL_C] = daw_carry;
  end

  // Full 8-bit operand range is decoded, no bits dropped
  assign use_index = (in_fixed_pool == 1'b0) & ext_set_en
    & (register_operand <= `IDX_MAX);
  // Indexed offsets stay inside the low 256 bytes; the carry is dropped on purpose
  assign idx_full = {1'b0, index_base} + {1'b0, register_operand};
  assign idx_sum = idx_full[7:0];
  assign ea = use_index ? {4'h0, idx_sum} :
    (in_fixed_pool ? {bank_pointer, register_operand} :
    {(register_operand[7] ? `ACC_BANK : 4'h0), register_operand});

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always @*
  begin
    case (state_r)
      ST_IDLE: state_nxt = (daw_go | dec_go) ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_nxt = (daw_go | dec_go) ? ST_EXEC : ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Next result values
  // ----------------------------------------------------------------
  reg [7:0] acc_out_nxt;
  reg acc_we_nxt;
  reg [7:0] reg_wdata_nxt;
  reg [11:0] reg_addr_nxt;
  reg reg_we_nxt;
  reg indexed_mode_nxt;
  reg [4:0] flags_out_nxt;
  reg [4:0] flags_we_nxt;

  // Data outputs hold until the next operation; strobes and indexed_mode last one cycle
  always @*
  begin
    acc_out_nxt = acc_out;
    acc_we_nxt = 1'b0;
    reg_wdata_nxt = reg_wdata;
    reg_addr_nxt = reg_addr;
    reg_we_nxt = 1'b0;
    indexed_mode_nxt = 1'b0;
    flags_out_nxt = flags_out;
    flags_we_nxt = `FLAGS_RST;
    // Decimal adjust wins if both strobes arrive; the core decodes one op
    if (daw_go)
    begin
      acc_out_nxt = daw_res;
      acc_we_nxt = 1'b1;
      flags_out_nxt = daw_flags;
      flags_we_nxt[`FL_C] = 1'b1;
    end
    else if (dec_go)
    begin
      reg_addr_nxt = ea;
      indexed_mode_nxt = use_index;
      flags_out_nxt = dec_flags;
      flags_we_nxt = `FLAGS_ALL;
      if (result_target_bit == `DEST_ACC)
      begin
        acc_out_nxt = dec_res;
        acc_we_nxt = 1'b1;
      end
      else
      begin
        reg_wdata_nxt = dec_res;
        reg_we_nxt = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_IDLE;
      acc_out <= `ACC_RST;
      acc_we <= 1'b0;
      reg_wdata <= `BYTE_RST;
      reg_addr <= `ADDR_RST;
      reg_we <= 1'b0;
      indexed_mode <= 1'b0;
      flags_out <= `FLAGS_RST;
      flags_we <= `FLAGS_RST;
      busy <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      busy <= state_nxt[1];
      acc_out <= acc_out_nxt;
      acc_we <= acc_we_nxt;
      reg_wdata <= reg_wdata_nxt;
      reg_addr <= reg_addr_nxt;
      reg_we <= reg_we_nxt;
      indexed_mode <= indexed_mode_nxt;
      flags_out <= flags_out_nxt;
      flags_we <= flags_we_nxt;
    end
  end

endmodule // bcd_adjust_and_decrement_unit

/* File: verification/bcd_dec_asserts.sv */
// Assertions for the decimal adjust and decrement unit.
// Assumes it is bound to the unit's top module; one clock domain.
`timescale 1ns/100ps
module bcd_dec_asserts
(
  input wire core_clk,
  input wire arst_n,
  input wire daw_go,
  input wire dec_go,
  input wire [7:0] acc_in,
  input wire [7:0] reg_in,
  input wire [7:0] register_operand,
  input wire result_target_bit,
  input wire in_fixed_pool,
  input wire ext_set_en,
  input wire [3:0] bank_pointer,
  input wire half_overflow_bit,
  input wire nibble_overflow_bit,
  input wire [7:0] acc_out,
  input wire acc_we,
  input wire [7:0] reg_wdata,
  input wire [11:0] reg_addr,
  input wire reg_we,
  input wire indexed_mode,
  input wire [4:0] flags_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Decrement only counts when decimal adjust does not win the cycle
  wire dec_t = dec_go && !daw_go;
  property p_lo;
    daw_go |=> acc_we && acc_out[3:0] ==
      $past(acc_in[3:0] + ((acc_in[3:0] > 4'h9 || half_overflow_bit) ? 4'h6 : 4'h0));
  endproperty
  a_lo: assert property (p_lo) else $error("low nibble wrong");
  property p_hi;
    daw_go && (acc_in[7:4] > 4'h9 || nibble_overflow_bit) |=> flags_out[0];
  endproperty
  a_hi: assert property (p_hi) else $error("carry not set");
  property p_dec;
    dec_t |=> ($past(result_target_bit) ?
      (reg_we && !acc_we && reg_wdata == $past(reg_in) - 8'h01) :
      (acc_we && !reg_we && acc_out == $past(reg_in) - 8'h01));
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");
  property p_idx;
    dec_t |=> indexed_mode == $past(!in_fixed_pool && ext_set_en && register_operand <= 8'h5f);
  endproperty
  a_idx: assert property (p_idx) else $error("indexed mode wrong");
  property p_bank;
    dec_t && in_fixed_pool |=> reg_addr == $past({bank_pointer, register_operand});
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");
  property p_acc;
    dec_t && !in_fixed_pool && !ext_set_en |=>
      reg_addr == $past({(register_operand[7] ? 4'hf : 4'h0), register_operand});
  endproperty
  a_acc: assert property (p_acc) else $error("access address wrong");
endmodule // bcd_dec_asserts
bind bcd_adjust_and_decrement_unit bcd_dec_asserts chk (.*);

/* File: verification/tb_bcd_adjust_and_decrement_unit.sv */
// Random self-checking bench for the decimal adjust and decrement unit.
// Assumes one operation per clock, results one edge later.
`timescale 1ns/100ps
module tb_bcd_adjust_and_decrement_unit;
  reg core_clk = 1'b0;
  reg arst_n = 1'b0;
  reg daw_go = 1'b0, dec_go = 1'b0, result_target_bit = 1'b0, in_fixed_pool = 1'b0;
  reg ext_set_en = 1'b0, half_overflow_bit = 1'b0, nibble_overflow_bit = 1'b0;
  reg [3:0] bank_pointer = 4'h0;
  reg [7:0] acc_in = 8'h00, reg_in = 8'h00, register_operand = 8'h00, index_base = 8'h00;
  wire [7:0] acc_out, reg_wdata;
  wire [11:0] reg_addr;
  wire [4:0] flags_out, flags_we;
  wire acc_we, reg_we, indexed_mode, busy;
  integer seed = 59, n_fail = 0, samples_checked = 0, cyc = 0, i, lo, hi, c, ex;
  bcd_adjust_and_decrement_unit dut (.*);
  initial forever #50 core_clk = ~core_clk;
  task chk(input [47:0] nm, input [11:0] e, input [11:0] s);
    samples_checked = samples_checked + 1;
    if (s !== e)
    begin
      $display("[ERR] %0s expected %h seen %h", nm, e, s);
      n_fail = n_fail + 1;
    end
  endtask
  task end_of_test;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Ceiling well above the 300 operations of the run
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 1000)
    begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    #1 arst_n = 1'b1;
    for (i = 0; i < 300; i = i + 1)
    begin
      // One reset in mid-run: outputs clear at once and the next op still lands
      if (i == 150)
      begin
        arst_n = 1'b0;
        #1;
        chk("rst", 0, {acc_we, reg_we, busy, flags_we, indexed_mode});
        chk("rsta", 0, reg_addr);
        chk("rsto", 0, acc_out);
        @(posedge core_clk);
        #1 arst_n = 1'b1;
      end
      {daw_go, dec_go, result_target_bit, in_fixed_pool, ext_set_en} = $random(seed);
      {half_overflow_bit, nibble_overflow_bit, bank_pointer} = $random(seed);
      {acc_in, reg_in, register_operand, index_base} = $random(seed);
      @(posedge core_clk);
      #1;
      chk("busy", daw_go || dec_go, busy);
      if (daw_go)
      begin
        lo = acc_in[3:0] + ((acc_in[3:0] > 9 || half_overflow_bit) ? 6 : 0);
        hi = acc_in[7:4] + lo / 16;
        c = nibble_overflow_bit || hi > 9;
        hi = hi + (c ? 6 : 0);
        chk("acc", 256 + (hi % 16) * 16 + lo % 16, {acc_we, acc_out});
        chk("carry", c, flags_out[0]);
        chk("dfwe", 1, flags_we);
        chk("drwe", 0, reg_we);
      end
      else if (dec_go)
      begin
        ex = 256 + (reg_in + 255) % 256;
        if (result_target_bit)
          chk("reg", ex, {reg_we, reg_wdata});
        else
          chk("acc", ex, {acc_we, acc_out});
        chk("we", result_target_bit ? 1 : 2, {acc_we, reg_we});
        hi = (ex / 128 % 2) * 16 + (reg_in == 128) * 8 + (ex == 256) * 4;
        hi = hi + (reg_in % 16 != 0) * 2 + (reg_in != 0);
        chk("flags", hi, flags_out);
        chk("fwe", 31, flags_we);
        c = !in_fixed_pool && ext_set_en && register_operand <= 95;
        chk("idx", c, indexed_mode);
        ex = in_fixed_pool ? bank_pointer * 256 + register_operand :
          c ? (index_base + register_operand) % 256 :
          (register_operand[7] ? 3840 : 0) + register_operand;
        chk("addr", ex, reg_addr);
      end
      else
      begin
        chk("we", 0, {acc_we, reg_we});
        chk("fwe", 0, flags_we);
      end
    end
    end_of_test;
  end
endmodule // tb_bcd_adjust_and_decrement_unit
